// ### src/dct_inverse_select_8x8_defs.vh
// constants for the 8x8 cosine transform engine
`ifndef DCT_INVERSE_SELECT_8X8_DEFS_VH
`define DCT_INVERSE_SELECT_8X8_DEFS_VH

// block geometry and port widths
`define BLK_SIDE 4'h8
`define IN_W 11
`define MID_W 14
`define OUT_W 12
`define ADDR_W 6
`define POS_W 7

// sequencing, in enabled clock cycles from the first sample
`define LATENCY 7'h48
`define WR_LAG 7'h08
`define RD_LEAD 7'h3D
`define ROW_LAST 3'h7
`define COL_LATCH 3'h6
`define POS_RESET 7'h00

// fixed point: coefficients carry 12 fraction bits
`define SH_P1_FWD 5'h08
`define SH_P1_INV 5'h0B
`define SH_P2_FWD 5'h0F
`define SH_P2_INV 5'h0D
`define SAT_MID 5'h0E
`define SAT_OUT 5'h0C

// cos(j*pi/16)/2 scaled by 4096; k=0 row uses 1/(2*sqrt2)
`define COEF_K0 13'sh05A8
`define COEF_J1 13'sh07D9
`define COEF_J2 13'sh0764
`define COEF_J3 13'sh06A7
`define COEF_J4 13'sh05A8
`define COEF_J5 13'sh0472
`define COEF_J6 13'sh0310
`define COEF_J7 13'sh0190

`endif

// ### src/dct_inverse_select_8x8_transform.v
// streaming 8x8 forward and inverse cosine transform engine
`timescale 1ns/1ps
`include "dct_inverse_select_8x8_defs.vh"

// Summary of operation
// - transforms 8x8 blocks, forward and inverse
// - standard 2d cosine, root-two; inverse quarter scale, forward half scale
// - forward: 8-bit samples in, 12-bit out
// - inverse: 11-bit coefficients in, 12-bit out
// - enable low freezes everything except reset
// - inverse select high means inverse transform
// - 11-bit sample input, 12-bit sample output
// - drives 6-bit write address, 14-bit data
// - drives read address, takes 14-bit data
// - valid pulses one cycle on first sample
// - forward output by columns, 72 cycles later
// - inverse: columns in, rows out
// - forward ranges -128..127 in, half-step out
// - one port writes only, one reads only
// - write port has no enable, always written
// - one sample per enabled cycle, no gaps

module dct_inverse_select_8x8_transform
(
    // clock and reset
    input wire clk_in,
    input wire nrst_in,
    // control
    input wire en_in,
    input wire start_in,
    input wire inverse_select_in,
    // sample stream
    input wire [`IN_W-1:0] sample_in,
    output wire [`OUT_W-1:0] sample_out,
    output wire ready_out,
    // intermediate ram
    input wire [`MID_W-1:0] ram_read_data_in,
    output wire [`ADDR_W-1:0] ram_write_addr_out,
    output wire [`MID_W-1:0] ram_write_data_out,
    output wire [`ADDR_W-1:0] ram_read_addr_out
);

// ----------------------------------------------------------------
// arithmetic helpers
// ----------------------------------------------------------------

// signed basis weight for frequency k at position n
function signed [12:0] coef;
    input [2:0] k;
    input [2:0] n;
    reg [6:0] prod;
    reg [4:0] m;
    reg neg;
    reg signed [12:0] mag;
    begin
        prod = {3'h0, n, 1'b1} * {4'h0, k};
        m = prod[4:0];
        neg = 1'b0;
        mag = 13'sh0000;
        if (m > 5'h10)
        begin
            m = 5'h00 - m;
        end
        if (m > 5'h08)
        begin
            m = 5'h10 - m;
            neg = 1'b1;
        end
        case (m)
            5'h01: mag = `COEF_J1;
            5'h02: mag = `COEF_J2;
            5'h03: mag = `COEF_J3;
            5'h04: mag = `COEF_J4;
            5'h05: mag = `COEF_J5;
            5'h06: mag = `COEF_J6;
            5'h07: mag = `COEF_J7;
            default: mag = 13'sh0000;
        endcase
        if (k == 3'h0)
        begin
            mag = `COEF_K0;
            neg = 1'b0;
        end
        coef = neg ? -mag : mag;
    end
endfunction

// one 8-point dot product; inverse uses the transposed basis
function signed [29:0] dot;
    input [8*`MID_W-1:0] v;
    input [2:0] o;
    input inv;
    reg signed [13:0] x;
    reg signed [29:0] acc;
    integer e;
    begin
        acc = 30'sh00000000;
        for (e = 0; e < 8; e = e + 1)
        begin
            x = v[8*`MID_W-1-`MID_W*e -: `MID_W];
            if (inv)
            begin
                acc = acc + x * coef(e[2:0], o);
            end
            else
            begin
                acc = acc + x * coef(o, e[2:0]);
            end
        end
        dot = acc;
    end
endfunction

// round half up, shift right, saturate to w bits
function signed [29:0] round_sat;
    input signed [29:0] acc;
    input [4:0] sh;
    input [4:0] w;
    reg signed [29:0] t;
    reg signed [29:0] hi;
    begin
        t = (acc + (30'sh00000001 <<< (sh - 5'h01))) >>> sh;
        hi = (30'sh00000001 <<< (w - 5'h01)) - 30'sh00000001;
        if (t > hi)
        begin
            t = hi;
        end
        else if (t < -hi - 30'sh00000001)
        begin
            t = -hi - 30'sh00000001;
        end
        round_sat = t;
    end
endfunction

// swaps row and column halves of a ram address
function [5:0] transpose;
    input [5:0] a;
    begin
        transpose = {a[2:0], a[5:3]};
    end
endfunction

// ----------------------------------------------------------------
// sequencing
// ----------------------------------------------------------------

reg run_q;
reg primed_q;
reg [`POS_W-1:0] pos_q;
reg ready_q;
reg [`ADDR_W-1:0] wr_addr_q;
reg [`ADDR_W-1:0] rd_addr_q;
reg [`MID_W-1:0] wr_data_q;
reg [`OUT_W-1:0] out_q;
reg [8*`MID_W-1:0] row_sh_q;
reg [8*`MID_W-1:0] row_vec_q;
reg [8*`MID_W-1:0] col_sh_q;
reg [8*`MID_W-1:0] col_vec_q;

wire [`POS_W-1:0] cur;
wire [`POS_W-1:0] wpos;
wire [`POS_W-1:0] rpos;
wire [2:0] col_k;
wire [`MID_W-1:0] in_ext;
wire [29:0] p1_val;
wire [29:0] p2_val;
wire [4:0] p1_sh;
wire [4:0] p2_sh;
wire first_out;

// start sample is position zero of the series
assign cur = start_in ? `POS_RESET : pos_q;
// write lags input by one row, read leads output by 11
assign wpos = cur - `WR_LAG;
assign rpos = cur - `RD_LEAD;
assign col_k = cur[2:0] + 3'h1;
assign first_out = (cur[5:0] == `ROW_LAST) &&
                   (primed_q || cur == `LATENCY - 7'h01);
assign in_ext = {{(`MID_W-`IN_W){sample_in[`IN_W-1]}}, sample_in};

// fraction bits of the stored intermediate depend on mode
assign p1_sh = inverse_select_in ? `SH_P1_INV : `SH_P1_FWD;
assign p2_sh = inverse_select_in ? `SH_P2_INV : `SH_P2_FWD;
assign p1_val = round_sat(dot(row_vec_q, cur[2:0], inverse_select_in),
                          p1_sh, `SAT_MID);
assign p2_val = round_sat(dot(col_vec_q, col_k, inverse_select_in),
                          p2_sh, `SAT_OUT);

always @(posedge clk_in or negedge nrst_in)
begin
    if (!nrst_in)
    begin
        run_q <= 1'b0;
        pos_q <= `POS_RESET;
        ready_q <= 1'b0;
    end
    else if (en_in)
    begin
        if (start_in || run_q)
        begin
            pos_q <= cur + 7'h01;
        end
        if (start_in)
        begin
            run_q <= 1'b1;
        end
        ready_q <= (start_in || run_q) && first_out;
    end
end

// primed once the first block's latency has run out
always @(posedge clk_in or negedge nrst_in)
begin
    if (!nrst_in)
    begin
        primed_q <= 1'b0;
    end
    else if (en_in)
    begin
        if (start_in)
        begin
            primed_q <= 1'b0;
        end
        else if (run_q && cur == `LATENCY - 7'h01)
        begin
            primed_q <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// datapath: row pass, intermediate ram, column pass
// ----------------------------------------------------------------

always @(posedge clk_in or negedge nrst_in)
begin
    if (!nrst_in)
    begin
        row_sh_q <= {8*`MID_W{1'b0}};
        row_vec_q <= {8*`MID_W{1'b0}};
        wr_addr_q <= 6'h00;
        wr_data_q <= 14'h0000;
    end
    else if (en_in)
    begin
        // gather eight inputs, then hold them for eight outputs
        row_sh_q <= {row_sh_q[7*`MID_W-1:0], in_ext};
        if (cur[2:0] == `ROW_LAST)
        begin
            row_vec_q <= {row_sh_q[7*`MID_W-1:0], in_ext};
        end
        // written every enabled cycle; block parity flips layout
        wr_data_q <= p1_val[`MID_W-1:0];
        wr_addr_q <= wpos[6] ? transpose(wpos[5:0]) : wpos[5:0];
    end
end

// ----------------------------------------------------------------
// column pass and sample output
// ----------------------------------------------------------------

always @(posedge clk_in or negedge nrst_in)
begin
    if (!nrst_in)
    begin
        col_sh_q <= {8*`MID_W{1'b0}};
        col_vec_q <= {8*`MID_W{1'b0}};
        rd_addr_q <= 6'h00;
        out_q <= 12'h000;
    end
    else if (en_in)
    begin
        // read order is the transpose of the write order
        rd_addr_q <= rpos[6] ? rpos[5:0] : transpose(rpos[5:0]);
        col_sh_q <= {col_sh_q[7*`MID_W-1:0], ram_read_data_in};
        if (cur[2:0] == `COL_LATCH)
        begin
            col_vec_q <= {col_sh_q[7*`MID_W-1:0], ram_read_data_in};
        end
        out_q <= p2_val[`OUT_W-1:0];
    end
end

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------

assign sample_out = out_q;
assign ready_out = ready_q;
assign ram_write_addr_out = wr_addr_q;
assign ram_write_data_out = wr_data_q;
assign ram_read_addr_out = rd_addr_q;

endmodule

// ### tb/dct_ram_model.sv
// 64x14 dual port ram model
`timescale 1ns/1ps
module dct_ram_model
(
    // clock
    input wire clk_in,
    input wire en_in,
    // ports
    input wire [5:0] wa_in,
    input wire [13:0] wd_in,
    input wire [5:0] ra_in,
    output reg [13:0] rd_out
);
    reg [13:0] mem_q [0:63];
    always @(posedge clk_in)
    begin
        if (en_in)
        begin
            mem_q[wa_in] <= wd_in;
            rd_out <= mem_q[ra_in];
        end
    end
endmodule

// ### tb/dct_inverse_select_8x8_transform_assertions.sv
// port checker for the transform engine
`timescale 1ns/1ps
module dct_inverse_select_8x8_transform_assertions
(
    input wire clk_in,
    input wire nrst_in,
    input wire en_in,
    input wire start_in,
    input wire [11:0] sample_out,
    input wire ready_out,
    input wire [5:0] ram_write_addr_out
);
    reg [7:0] n_q;
    always @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            n_q <= 8'h00;
        else if (en_in && start_in)
            n_q <= 8'h01;
        else if (en_in && n_q != 8'h00 && n_q != 8'hFF)
            n_q <= n_q + 8'h01;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    ready_pulse_a: assert property (ready_out && en_in |=> !ready_out)
        else $error("ready too long");
    stall_out_a: assert property (!en_in |=> $stable({ready_out, sample_out}))
        else $error("output moved in stall");
    stall_ram_a: assert property (!en_in |=> $stable(ram_write_addr_out))
        else $error("address moved in stall");
    first_ready_a: assert property (n_q == 8'h48 |-> ready_out)
        else $error("no ready at 72");
    no_early_a: assert property (n_q > 0 && n_q < 72 |-> !ready_out)
        else $error("early ready");
    next_block_a: assert property (n_q == 8'h88 |-> ready_out)
        else $error("no ready for next block");
    quiet_gap_a: assert property (n_q > 72 && n_q < 136 |-> !ready_out)
        else $error("ready inside block");
    reset_clear_a: assert property (disable iff (1'b0) !nrst_in |->
        !ready_out && sample_out == 12'h000 && ram_write_addr_out == 6'h00)
        else $error("outputs live in reset");
    start_c: cover property (en_in && start_in);
    ready_stall_c: cover property (ready_out && !en_in);
    second_c: cover property (n_q == 8'h88 && ready_out);
endmodule
bind dct_inverse_select_8x8_transform dct_inverse_select_8x8_transform_assertions chk
(
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .en_in(en_in),
    .start_in(start_in),
    .sample_out(sample_out),
    .ready_out(ready_out),
    .ram_write_addr_out(ram_write_addr_out)
);

// ### tb/dct_inverse_select_8x8_transform_bench.sv
// self-checking bench for the transform engine
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin \
miscompares++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module dct_inverse_select_8x8_transform_bench;
    reg clk_in = 1'b0;
    reg nrst_in = 1'b0;
    reg en_in = 1'b0;
    reg start_in = 1'b0;
    reg inverse_select_in = 1'b0;
    reg [10:0] sample_in = 11'h000;
    wire [11:0] sample_out;
    wire ready_out;
    wire [13:0] rd, wd;
    wire [5:0] wa, ra;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    reg [15:0] rnd_q = 16'hD209;
    reg signed [10:0] blk [0:63];
    always #12.5 clk_in = ~clk_in;
    dct_inverse_select_8x8_transform uut (.clk_in(clk_in), .nrst_in(nrst_in),
        .en_in(en_in), .start_in(start_in),
        .inverse_select_in(inverse_select_in), .sample_in(sample_in),
        .sample_out(sample_out), .ready_out(ready_out),
        .ram_read_data_in(rd), .ram_write_addr_out(wa),
        .ram_write_data_out(wd), .ram_read_addr_out(ra));
    dct_ram_model ram (.clk_in(clk_in), .en_in(en_in), .wa_in(wa),
        .wd_in(wd), .ra_in(ra), .rd_out(rd));
    function reg [15:0] lfsr(input reg [15:0] x);
        lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function real wt(input int x, input int f);
        wt = $cos((2 * x + 1) * f * 3.14159265358979 / 16.0);
        if (f == 0)
            wt = wt * 0.70710678118655;
    endfunction
    function int expect_at(input reg inv, input int p);
        real acc;
        int ta, tb, a, b;
        ta = inv ? p / 8 : p % 8;
        tb = inv ? p % 8 : p / 8;
        acc = 0.0;
        for (int q = 0; q < 64; q++)
        begin
            a = inv ? q % 8 : q / 8;
            b = inv ? q / 8 : q % 8;
            acc += blk[q] * (inv ? wt(ta, a) * wt(tb, b)
                : wt(a, ta) * wt(b, tb));
        end
        acc = inv ? acc / 4.0 : acc / 2.0;
        expect_at = $rtoi(acc < 0.0 ? acc - 0.5 : acc + 0.5);
        if (expect_at > 2047)
            expect_at = 2047;
        if (expect_at < -2048)
            expect_at = -2048;
    endfunction
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task run(input reg inv, input reg stall, input int kind);
        int c, d;
        bit ok;
        c = 0;
        for (int p = 0; p < 64; p++)
        begin
            rnd_q = lfsr(rnd_q);
            if (kind == 1)
                blk[p] = inv ? (p == 0 ? 11'h3FF : 11'h000) : 11'h07F;
            else if (kind == 2)
                blk[p] = 11'h780;
            else
                blk[p] = inv ? {{2{rnd_q[8]}}, rnd_q[8:0]}
                    : {{3{rnd_q[7]}}, rnd_q[7:0]};
        end
        while (c < 136)
        begin
            @(negedge clk_in);
            if (c >= 72)
            begin
                d = $signed(sample_out) - expect_at(inv, c - 72);
                `CHK("ready_out", c == 72, ready_out)
                ok = ^sample_out !== 1'bx && d * d <= 4;
                `CHK("sample_out", 1'b1, ok)
            end
            rnd_q = lfsr(rnd_q);
            en_in = !(stall && rnd_q[1:0] == 2'b00);
            start_in = en_in ? c == 0 : rnd_q[2];
            inverse_select_in = en_in ? inv : rnd_q[3];
            sample_in = en_in && c < 64 ? blk[c] : rnd_q[10:0];
            c = c + en_in;
        end
    endtask
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            conclude;
        end
    end
    initial
    begin
        repeat (3) @(negedge clk_in);
        nrst_in = 1'b1;
        for (int t = 0; t < 7; t++)
        begin
            run(t[0], t >= 5, t % 3);
            $display("test %0d done", t);
        end
        nrst_in = 1'b0;
        #1;
        `CHK("sample_out", 12'h000, sample_out)
        `CHK("ram_write_addr_out", 6'h00, wa)
        `CHK("ram_write_data_out", 14'h0000, wd)
        `CHK("ram_read_addr_out", 6'h00, ra)
        `CHK("ready_out", 1'b0, ready_out)
        @(negedge clk_in);
        nrst_in = 1'b1;
        run(1'b0, 1'b0, 0);
        $display("test reset done");
        conclude;
    end
endmodule
